// File: design/usb_desc_defs.svh
// descriptor constants for the endpoint, other-speed and qualifier descriptor source
`ifndef USB_DESC_DEFS_SVH
`define USB_DESC_DEFS_SVH
`define EP_LEN          8'h07
`define EP_TYPE         8'h05
`define EP_OUT_ADDR     8'h02
`define EP_BULK_ATTR    8'h02
`define EP_BULK_IVL     8'h00
`define EP_FS_MPS       16'h0040
`define EP_HS_MPS       16'h0200
`define EP_INT_ADDR     8'h83
`define EP_INT_ATTR     8'h03
`define EP_INT_MPS      16'h0010
`define EP_INT_IVL_HS   8'h04
`define EP_INT_IVL_FS   8'h01
`define OSC_LEN         8'h09
`define OSC_TYPE        8'h07
`define OSC_TOTAL       16'h0027
`define OSC_NUM_IF      8'h01
`define OSC_CFG_VAL     8'h01
`define OSC_STR_IDX     8'h00
`define OSC_ATTR        8'he0
`define OSC_PWR_SELF    8'h01
`define OSC_PWR_BUS     8'hfa
`define QUAL_LEN        8'h0a
`define QUAL_TYPE       8'h06
`define QUAL_BCD        16'h0210
`define QUAL_CLASS      8'hff
`define QUAL_SUBCLASS   8'h00
`define QUAL_PROTO      8'hff
`define QUAL_MPS0       8'h40
`define QUAL_NUM_CFG    8'h01
`define QUAL_RSVD       8'h00
`define DT_CONFIG       8'h02
`define DT_QUALIFIER    8'h06
`define DT_OTHER_SPEED  8'h07
`define DT_ENDPOINT     8'h05
`define EP_IDX_BULK_OUT 8'h01
`define EP_IDX_INT      8'h02
`endif

// File: design/usb_desc_pkg.sv
// types for the descriptor source
package usb_desc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_STALL = 3'b100
  } desc_state_t;
endpackage

// File: design/desc_byte_rom.sv
// combinational-to-registered byte lookup for four descriptor images, picked by i_sel
`timescale 1ns/10ps
`include "usb_desc_defs.svh"
module desc_byte_rom (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_sel,
  input  wire logic [3:0] i_idx,
  input  wire logic       i_hs,
  input  wire logic       i_nv_valid,
  input  wire logic [7:0] i_nv_ivl_hs,
  input  wire logic [7:0] i_nv_ivl_fs,
  input  wire logic [7:0] i_osc_str,
  input  wire logic [7:0] i_osc_attr,
  input  wire logic [7:0] i_osc_pwr,
  input  wire logic [63:0] i_qual_fields,
  output logic      [7:0] o_byte
);
  logic [7:0]  byte_nxt;
  logic [15:0] mps;
  logic [7:0]  ivl;
  logic [15:0] int_mps;
  logic [15:0] osc_tot;
  always_comb
  begin
    // literals cannot be part-selected, so wide constants go through a variable
    int_mps = `EP_INT_MPS;
    osc_tot = `OSC_TOTAL;
    mps = i_hs ? `EP_HS_MPS : `EP_FS_MPS;
    ivl = i_nv_valid ? (i_hs ? i_nv_ivl_hs : i_nv_ivl_fs)
                     : (i_hs ? `EP_INT_IVL_HS : `EP_INT_IVL_FS);
    byte_nxt = 8'h00;
    case (i_sel)
      2'd0:
      begin
        // bulk-out endpoint, fixed except max packet size, which follows i_hs
        case (i_idx)
          4'd0: byte_nxt = `EP_LEN;
          4'd1: byte_nxt = `EP_TYPE;
          4'd2: byte_nxt = `EP_OUT_ADDR;
          4'd3: byte_nxt = `EP_BULK_ATTR;
          4'd4: byte_nxt = mps[7:0];
          4'd5: byte_nxt = mps[15:8];
          4'd6: byte_nxt = `EP_BULK_IVL;
          default: byte_nxt = 8'h00;
        endcase
      end
      2'd1:
      begin
        case (i_idx)
          4'd0: byte_nxt = `EP_LEN;
          4'd1: byte_nxt = `EP_TYPE;
          4'd2: byte_nxt = `EP_INT_ADDR;
          4'd3: byte_nxt = `EP_INT_ATTR;
          4'd4: byte_nxt = int_mps[7:0];
          4'd5: byte_nxt = int_mps[15:8];
          4'd6: byte_nxt = ivl;
          default: byte_nxt = 8'h00;
        endcase
      end
      2'd2:
      begin
        case (i_idx)
          4'd0: byte_nxt = `OSC_LEN;
          4'd1: byte_nxt = `OSC_TYPE;
          4'd2: byte_nxt = osc_tot[7:0];
          4'd3: byte_nxt = osc_tot[15:8];
          4'd4: byte_nxt = `OSC_NUM_IF;
          4'd5: byte_nxt = `OSC_CFG_VAL;
          4'd6: byte_nxt = i_osc_str;
          4'd7: byte_nxt = i_osc_attr;
          4'd8: byte_nxt = i_osc_pwr;
          default: byte_nxt = 8'h00;
        endcase
      end
      default:
      begin
        case (i_idx)
          4'd0: byte_nxt = `QUAL_LEN;
          4'd1: byte_nxt = `QUAL_TYPE;
          4'd2: byte_nxt = i_qual_fields[7:0];
          4'd3: byte_nxt = i_qual_fields[15:8];
          4'd4: byte_nxt = i_qual_fields[23:16];
          4'd5: byte_nxt = i_qual_fields[31:24];
          4'd6: byte_nxt = i_qual_fields[39:32];
          4'd7: byte_nxt = `QUAL_MPS0;
          4'd8: byte_nxt = `QUAL_NUM_CFG;
          default: byte_nxt = `QUAL_RSVD;
        endcase
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_byte <= 8'h00;
    else
      o_byte <= byte_nxt;
  end
endmodule // desc_byte_rom

// File: design/usb_desc_source.sv
// descriptor byte source for bulk-out, interrupt, other-speed and qualifier descriptors
`timescale 1ns/10ps
`include "usb_desc_defs.svh"
module usb_desc_source (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hs_mode,
  input  wire logic        i_self_powered,
  input  wire logic        i_nv_valid,
  input  wire logic [7:0]  i_nv_ivl_hs,
  input  wire logic [7:0]  i_nv_ivl_fs,
  input  wire logic [7:0]  i_nv_cfg_str_hs,
  input  wire logic [7:0]  i_nv_cfg_str_fs,
  input  wire logic [7:0]  i_nv_cfg_attr_hs,
  input  wire logic [7:0]  i_nv_cfg_attr_fs,
  input  wire logic [7:0]  i_nv_cfg_pwr_hs,
  input  wire logic [7:0]  i_nv_cfg_pwr_fs,
  input  wire logic [39:0] i_nv_dev_hs,
  input  wire logic [39:0] i_nv_dev_fs,
  input  wire logic        i_req,
  input  wire logic [7:0]  i_desc_type,
  input  wire logic [7:0]  i_desc_index,
  input  wire logic [15:0] i_req_len,
  input  wire logic        i_byte_ack,
  output logic             o_byte_valid,
  output logic      [7:0]  o_byte,
  output logic             o_last,
  output logic             o_stall,
  output logic             o_busy
);
  logic                     rst_meta_r;
  logic                     rst_sync_r;
  usb_desc_pkg::desc_state_t state_r;
  logic [1:0]               sel_r;
  logic [3:0]               idx_r;
  logic [3:0]               end_r;
  logic [7:0]               rom_byte;
  logic                     fetch_r;
  logic [1:0]               sel_nxt;
  logic [3:0]               len_nxt;
  logic                     hit_nxt;
  logic [7:0]               osc_str;
  logic [7:0]               osc_attr;
  logic [7:0]               osc_pwr;
  logic [63:0]              qual;
  logic [39:0]              dev_other;
  logic [1:0]               rom_sel;
  logic [3:0]               rom_idx;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // loaded other-speed fields come from the opposite speed store
  always_comb
  begin
    if (i_nv_valid)
    begin
      osc_str  = i_hs_mode ? i_nv_cfg_str_fs : i_nv_cfg_str_hs;
      osc_attr = i_hs_mode ? i_nv_cfg_attr_fs : i_nv_cfg_attr_hs;
      osc_pwr  = i_hs_mode ? i_nv_cfg_pwr_fs : i_nv_cfg_pwr_hs;
      dev_other = i_hs_mode ? i_nv_dev_fs : i_nv_dev_hs;
    end
    else
    begin
      osc_str  = `OSC_STR_IDX;
      osc_attr = `OSC_ATTR;
      osc_pwr  = i_self_powered ? `OSC_PWR_SELF : `OSC_PWR_BUS;
      dev_other = {`QUAL_PROTO, `QUAL_SUBCLASS, `QUAL_CLASS, `QUAL_BCD};
    end
    qual = {24'h000000, dev_other};
  end

  // request decode
  always_comb
  begin
    sel_nxt = 2'd0;
    len_nxt = 4'd0;
    hit_nxt = 1'b1;
    if (i_desc_type == `DT_ENDPOINT && i_desc_index == `EP_IDX_BULK_OUT)
    begin
      sel_nxt = 2'd0;
      len_nxt = 4'(`EP_LEN);
    end
    else if (i_desc_type == `DT_ENDPOINT && i_desc_index == `EP_IDX_INT)
    begin
      sel_nxt = 2'd1;
      len_nxt = 4'(`EP_LEN);
    end
    else if (i_desc_type == `DT_OTHER_SPEED)
    begin
      sel_nxt = 2'd2;
      len_nxt = 4'(`OSC_LEN);
    end
    else if (i_desc_type == `DT_QUALIFIER)
    begin
      sel_nxt = 2'd3;
      len_nxt = 4'(`QUAL_LEN);
    end
    else
      hit_nxt = 1'b0;
    // a short host read truncates the data stage
    if (i_req_len < {12'h000, len_nxt})
      len_nxt = i_req_len[3:0];
  end

  // rom address leads sel_r/idx_r by one edge, so its register
  // already holds the new byte when fetch_r is seen
  always_comb
  begin
    rom_sel = sel_r;
    rom_idx = idx_r;
    if (state_r == usb_desc_pkg::ST_IDLE && i_req && hit_nxt && len_nxt != 4'd0)
    begin
      rom_sel = sel_nxt;
      rom_idx = 4'd0;
    end
    else if (state_r == usb_desc_pkg::ST_SEND && !fetch_r && o_byte_valid && i_byte_ack
             && idx_r != end_r)
      rom_idx = idx_r + 4'd1;
  end

  desc_byte_rom u_rom (
    .i_clk         (i_clk),
    .i_rst_n       (rst_sync_r),
    .i_sel         (rom_sel),
    .i_idx         (rom_idx),
    .i_hs          (i_hs_mode),
    .i_nv_valid    (i_nv_valid),
    .i_nv_ivl_hs   (i_nv_ivl_hs),
    .i_nv_ivl_fs   (i_nv_ivl_fs),
    .i_osc_str     (osc_str),
    .i_osc_attr    (osc_attr),
    .i_osc_pwr     (osc_pwr),
    .i_qual_fields (qual),
    .o_byte        (rom_byte)
  );

  // fetch_r marks the cycle the rom register holds byte idx_r
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      state_r      <= usb_desc_pkg::ST_IDLE;
      sel_r        <= 2'd0;
      idx_r        <= 4'd0;
      end_r        <= 4'd0;
      fetch_r      <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte       <= 8'h00;
      o_last       <= 1'b0;
      o_stall      <= 1'b0;
      o_busy       <= 1'b0;
    end
    else
    begin
      o_stall <= 1'b0;
      fetch_r <= 1'b0;
      case (state_r)
        usb_desc_pkg::ST_IDLE:
        begin
          if (i_req && hit_nxt && len_nxt != 4'd0)
          begin
            sel_r   <= sel_nxt;
            idx_r   <= 4'd0;
            end_r   <= len_nxt - 4'd1;
            fetch_r <= 1'b1;
            o_busy  <= 1'b1;
            state_r <= usb_desc_pkg::ST_SEND;
          end
          else if (i_req)
          begin
            o_stall <= ~hit_nxt;
            state_r <= usb_desc_pkg::ST_STALL;
          end
        end
        usb_desc_pkg::ST_SEND:
        begin
          if (fetch_r)
          begin
            o_byte       <= rom_byte;
            o_byte_valid <= 1'b1;
            o_last       <= (idx_r == end_r);
          end
          else if (o_byte_valid && i_byte_ack)
          begin
            o_byte_valid <= 1'b0;
            o_last       <= 1'b0;
            if (idx_r == end_r)
            begin
              o_busy  <= 1'b0;
              state_r <= usb_desc_pkg::ST_IDLE;
            end
            else
            begin
              idx_r   <= idx_r + 4'd1;
              fetch_r <= 1'b1;
            end
          end
        end
        default:
          state_r <= usb_desc_pkg::ST_IDLE;
      endcase
    end
  end

  property p_qual_len;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && !$past(o_byte_valid) && sel_r == 2'd3 && idx_r == 4'd0)
      |-> o_byte == `QUAL_LEN;
  endproperty
  a_qual_len: assert property (p_qual_len) else $error("qualifier length wrong");

  property p_bulk_type;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd0 && idx_r == 4'd1) |-> o_byte == `EP_TYPE;
  endproperty
  a_bulk_type: assert property (p_bulk_type) else $error("bulk type wrong");

  property p_bulk_addr;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd0 && idx_r == 4'd2) |-> o_byte == `EP_OUT_ADDR;
  endproperty
  a_bulk_addr: assert property (p_bulk_addr) else $error("bulk address wrong");

  property p_bulk_mps;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd0 && idx_r == 4'd5 && $stable(i_hs_mode))
      |-> o_byte == (i_hs_mode ? 8'h02 : 8'h00);
  endproperty
  a_bulk_mps: assert property (p_bulk_mps) else $error("bulk packet size wrong");

  property p_int_addr;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd1 && idx_r == 4'd2) |-> o_byte == `EP_INT_ADDR;
  endproperty
  a_int_addr: assert property (p_int_addr) else $error("interrupt address wrong");

  property p_int_ivl;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd1 && idx_r == 4'd6 && !i_nv_valid && $stable(i_hs_mode)
      && $stable(i_nv_valid)) |-> o_byte == (i_hs_mode ? `EP_INT_IVL_HS : `EP_INT_IVL_FS);
  endproperty
  a_int_ivl: assert property (p_int_ivl) else $error("interval default wrong");

  property p_osc_type;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd2 && idx_r == 4'd1) |-> o_byte == `OSC_TYPE;
  endproperty
  a_osc_type: assert property (p_osc_type) else $error("other speed type wrong");

  property p_qual_rsvd;
    @(posedge i_clk) disable iff (!rst_sync_r)
    (o_byte_valid && sel_r == 2'd3 && idx_r == 4'd9) |-> o_byte == `QUAL_RSVD && o_last;
  endproperty
  a_qual_rsvd: assert property (p_qual_rsvd) else $error("reserved byte wrong");

  property p_first_byte;
    @(posedge i_clk) disable iff (!rst_sync_r)
    ($rose(o_busy)) |-> ##1 o_byte_valid && idx_r == 4'd0;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte late");
endmodule // usb_desc_source

// File: tb/usb_host_model.sv
// host-side model: issues get-descriptor reads and accepts data-stage bytes
`timescale 1ns/10ps
module usb_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_last,
  input  wire logic        i_stall,
  output logic             o_req,
  output logic      [7:0]  o_desc_type,
  output logic      [7:0]  o_desc_index,
  output logic      [15:0] o_req_len,
  output logic             o_byte_ack
);
  logic [7:0] rx_q[$];
  logic       stalled;
  logic       tmo;

  initial
  begin
    o_req = 1'b0;
    o_desc_type = 8'h00;
    o_desc_index = 8'h00;
    o_req_len = 16'h0000;
    o_byte_ack = 1'b0;
  end

  // slow acks one cycle in three, so bytes must stand while unacked
  task automatic get(input logic [7:0] t, input logic [7:0] ix, input logic [15:0] len,
                     input logic slow);
    int   n;
    logic done;
    rx_q = {};
    stalled = 1'b0;
    done = 1'b0;
    n = 0;
    repeat (3) @(posedge i_clk);
    #1;
    o_req = 1'b1;
    o_desc_type = t;
    o_desc_index = ix;
    o_req_len = len;
    @(posedge i_clk);
    #1;
    o_req = 1'b0;
    // released request lines must not keep looking valid
    o_desc_type = ~t;
    o_desc_index = ~ix;
    o_req_len = ~len;
    o_byte_ack = ~slow;
    while (!done && n < 60)
    begin
      @(negedge i_clk);
      if (i_stall)
      begin
        stalled = 1'b1;
        done = 1'b1;
      end
      if (i_byte_valid && o_byte_ack)
      begin
        rx_q.push_back(i_byte);
        done = i_last;
      end
      @(posedge i_clk);
      #1;
      o_byte_ack = !done && (slow ? (n % 3 == 1) : 1'b1);
      n++;
    end
    tmo = !done && (len != 16'h0000);
  endtask
endmodule // usb_host_model

// File: tb/tb.sv
// self-checking bench for the descriptor byte source
`timescale 1ns/10ps
module tb;
  logic        clk, rst_n, hs, self_pwr, nv;
  logic        req, ack, bv, last, stall, busy;
  logic [7:0]  typ, idx, byt;
  logic [15:0] len;
  logic [7:0]  ivl_hs, ivl_fs, str_hs, str_fs, attr_hs, attr_fs, pwr_hs, pwr_fs;
  logic [39:0] dev_hs, dev_fs;
  int          err_count;
  int          checked;
  int          busy_cyc;

  usb_desc_source dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hs_mode(hs), .i_self_powered(self_pwr),
    .i_nv_valid(nv), .i_nv_ivl_hs(ivl_hs), .i_nv_ivl_fs(ivl_fs),
    .i_nv_cfg_str_hs(str_hs), .i_nv_cfg_str_fs(str_fs),
    .i_nv_cfg_attr_hs(attr_hs), .i_nv_cfg_attr_fs(attr_fs),
    .i_nv_cfg_pwr_hs(pwr_hs), .i_nv_cfg_pwr_fs(pwr_fs),
    .i_nv_dev_hs(dev_hs), .i_nv_dev_fs(dev_fs), .i_req(req), .i_desc_type(typ),
    .i_desc_index(idx), .i_req_len(len), .i_byte_ack(ack), .o_byte_valid(bv),
    .o_byte(byt), .o_last(last), .o_stall(stall), .o_busy(busy)
  );

  usb_host_model host (
    .i_clk(clk), .i_byte_valid(bv), .i_byte(byt), .i_last(last), .i_stall(stall),
    .o_req(req), .o_desc_type(typ), .o_desc_index(idx), .o_req_len(len),
    .o_byte_ack(ack)
  );

  always #4 clk = ~clk;

  // edges with busy high; two per byte when acks come at once
  always @(posedge clk)
    if (busy === 1'b1)
      busy_cyc <= busy_cyc + 1;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // expected image e holds byte 0 in its most significant used byte
  task automatic xfer(input string what, input logic [7:0] t, input logic [7:0] ix,
                      input logic [15:0] n, input logic [79:0] e, input logic slow);
    busy_cyc = 0;
    host.get(t, ix, n, slow);
    if (host.tmo)
    begin
      $display("MISMATCH %s expected last seen timeout", what);
      err_count++;
      results();
    end
    else
    begin
      chk({what, " count"}, 16'(host.rx_q.size()), n);
      if (!slow)
        chk({what, " busy"}, 16'(busy_cyc), 16'(2 * n));
      for (int i = 0; i < host.rx_q.size(); i++)
        chk(what, {8'h00, host.rx_q[i]}, {8'h00, e[8*(int'(n)-1-i) +: 8]});
    end
  endtask

  task automatic cfg(input logic h, input logic s, input logic v);
    @(posedge clk);
    #1;
    hs = h;
    self_pwr = s;
    nv = v;
  endtask

  task automatic t_bulk();
    cfg(1'b1, 1'b0, 1'b1);
    xfer("bulk hs", 8'h05, 8'h01, 16'd7, 80'h07050202000200, 1'b0);
    cfg(1'b0, 1'b0, 1'b1);
    xfer("bulk fs", 8'h05, 8'h01, 16'd7, 80'h07050202400000, 1'b1);
    $display("test bulk done");
  endtask

  task automatic t_int();
    cfg(1'b1, 1'b1, 1'b1);
    xfer("int hs nv", 8'h05, 8'h02, 16'd7, 80'h0705830310000b, 1'b0);
    cfg(1'b0, 1'b1, 1'b1);
    xfer("int fs nv", 8'h05, 8'h02, 16'd7, 80'h0705830310000c, 1'b0);
    cfg(1'b1, 1'b1, 1'b0);
    xfer("int hs def", 8'h05, 8'h02, 16'd7, 80'h07058303100004, 1'b1);
    cfg(1'b0, 1'b1, 1'b0);
    xfer("int fs def", 8'h05, 8'h02, 16'd7, 80'h07058303100001, 1'b0);
    $display("test int done");
  endtask

  task automatic t_osc();
    cfg(1'b1, 1'b1, 1'b1);
    xfer("osc hs", 8'h07, 8'h00, 16'd9, 80'h090727000101_06c064, 1'b0);
    cfg(1'b0, 1'b1, 1'b1);
    xfer("osc fs", 8'h07, 8'h00, 16'd9, 80'h090727000101_05a032, 1'b1);
    cfg(1'b1, 1'b1, 1'b0);
    xfer("osc self", 8'h07, 8'h00, 16'd9, 80'h090727000101_00e001, 1'b0);
    cfg(1'b0, 1'b0, 1'b0);
    xfer("osc bus", 8'h07, 8'h00, 16'd9, 80'h090727000101_00e0fa, 1'b0);
    $display("test osc done");
  endtask

  task automatic t_qual();
    cfg(1'b1, 1'b1, 1'b1);
    xfer("qual hs", 8'h06, 8'h00, 16'd10, 80'h0a060002332211400100, 1'b0);
    cfg(1'b0, 1'b1, 1'b1);
    xfer("qual fs", 8'h06, 8'h00, 16'd10, 80'h0a060102665544400100, 1'b1);
    cfg(1'b1, 1'b1, 1'b0);
    xfer("qual def", 8'h06, 8'h00, 16'd10, 80'h0a061002ff00ff400100, 1'b0);
    $display("test qual done");
  endtask

  task automatic t_misc();
    cfg(1'b1, 1'b1, 1'b0);
    xfer("qual short", 8'h06, 8'h00, 16'd3, 80'h0a0610, 1'b1);
    busy_cyc = 0;
    host.get(8'h02, 8'h00, 16'd9, 1'b0);
    chk("stall", {15'h0000, host.stalled}, 16'h0001);
    chk("stall count", 16'(host.rx_q.size()), 16'h0000);
    chk("stall busy", 16'(busy_cyc), 16'h0000);
    busy_cyc = 0;
    host.get(8'h06, 8'h00, 16'd0, 1'b0);
    chk("zero len count", 16'(host.rx_q.size()), 16'h0000);
    chk("zero len stall", {15'h0000, host.stalled}, 16'h0000);
    chk("zero len busy", 16'(busy_cyc), 16'h0000);
    $display("test misc done");
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    hs = 1'b1;
    self_pwr = 1'b1;
    nv = 1'b0;
    err_count = 0;
    checked = 0;
    // stored images set every programmer-owned field away from its default
    ivl_hs = 8'h0b;
    ivl_fs = 8'h0c;
    str_hs = 8'h05;
    str_fs = 8'h06;
    attr_hs = 8'ha0;
    attr_fs = 8'hc0;
    pwr_hs = 8'h32;
    pwr_fs = 8'h64;
    dev_hs = 40'h4455660201;
    dev_fs = 40'h1122330200;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_bulk();
    t_int();
    t_osc();
    t_qual();
    t_misc();
    results();
  end
endmodule // tb
